// file: test/interval_timer_regs_tb.sv
// Self-checking bench for the interval timer registers.
// Assumes timer_master drives the register port; expectations come from int math.
`timescale 1ns/1ps

module interval_timer_regs_tb;
  import interval_timer_pkg::*;
  localparam logic [31:0] PER = 32'h0000_000a; // Short default keeps the run brief
  logic        ref_clk;
  logic        rst_b;
  logic [2:0]  address;
  logic        write;
  logic        read;
  logic [15:0] writedata;
  logic [15:0] readdata;
  logic        irq;
  logic        zero_reach_pulse;
  logic        system_restart_request;
  logic [15:0] d;
  logic [31:0] v1;
  logic [31:0] v2;
  logic [31:0] lfsr;
  logic [15:0] pl;
  int          err_total;
  int          num_checks;
  int          n;

  interval_timer_regs #(.PERIOD_DEFAULT(PER)) u_interval_timer_regs (
    .ref_clk(ref_clk), .rst_b(rst_b), .address(address), .write(write), .read(read),
    .writedata(writedata), .readdata(readdata), .irq(irq),
    .zero_reach_pulse(zero_reach_pulse), .system_restart_request(system_restart_request));

  timer_master u_timer_master (
    .ref_clk(ref_clk), .readdata(readdata), .address(address), .write(write),
    .read(read), .writedata(writedata));

  // ----------------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------------
  function automatic logic [31:0] lfsr_step(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr_step

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic results();
    $display("Checks %0d mismatches %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : results

  // Snapshot and read both halves; takes are six cycles apart when repeated
  task automatic snap(output logic [31:0] v);
    u_timer_master.wr(ADDR_CAP_LO, REG_ZERO);
    u_timer_master.rd(ADDR_CAP_LO, v[15:0]);
    u_timer_master.rd(ADDR_CAP_HI, v[31:16]);
  endtask : snap

  // Bounded wait on irq (sel 0) or the zero pulse (sel 1); n counts cycles
  task automatic wait_for(input int sel, output int k);
    k = 0;
    do begin
      @(posedge ref_clk);
      #1 k++;
      if (k > 100) begin
        err_total++;
        results();
      end
    end while (((sel == 0) ? irq : zero_reach_pulse) !== 1'b1);
  endtask : wait_for

  task automatic status(input logic [1:0] exp);
    u_timer_master.rd(ADDR_STATUS, d);
    chk({30'h0, d[1:0]}, {30'h0, exp});
  endtask : status

  // Free-running clock, 100 ns period
  initial begin
    ref_clk = 1'b0;
    forever #50 ref_clk = ~ref_clk;
  end

  // ----------------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------------
  initial begin
    rst_b = 1'b0;
    err_total = 0;
    num_checks = 0;
    lfsr = 32'h6e85;
    repeat (8) @(posedge ref_clk);
    rst_b <= 1'b1;
    status(2'b00);
    u_timer_master.rd(ADDR_CONTROL, d);
    chk({16'h0, d}, 32'h0);
    u_timer_master.rd(3'h6, d);
    chk({16'h0, d}, 32'h0);
    snap(v1);
    chk(v1, PER);
    // Random low half; kept at or above 0x100 so six-cycle differences never borrow
    lfsr = lfsr_step(lfsr);
    pl = {4'h0, lfsr[11:0]} | 16'h0100;
    u_timer_master.wr(ADDR_PER_HI, 16'h0001);
    u_timer_master.wr(ADDR_PER_LO, pl);
    snap(v1);
    chk(v1, {16'h0001, pl});
    u_timer_master.rd(ADDR_PER_LO, d);
    chk({16'h0, d}, {16'h0, pl});
    u_timer_master.rd(ADDR_PER_HI, d);
    chk({16'h0, d}, 32'h1);
    status(2'b00);
    u_timer_master.wr(ADDR_CONTROL, 16'h0004);
    snap(v1);
    snap(v2);
    chk(v2, v1 - 32'd6);
    u_timer_master.wr(ADDR_STATUS, REG_ZERO);
    status(2'b10);
    u_timer_master.wr(ADDR_CONTROL, 16'h0008);
    snap(v1);
    snap(v2);
    chk(v2, v1);
    status(2'b00);
    u_timer_master.wr(ADDR_CONTROL, 16'h0003);
    u_timer_master.rd(ADDR_CONTROL, d);
    chk({30'h0, d[1:0]}, 32'h3);
    // One-shot run with period 5 and interrupt enabled
    u_timer_master.wr(ADDR_PER_HI, REG_ZERO);
    u_timer_master.wr(ADDR_PER_LO, 16'h0005);
    u_timer_master.wr(ADDR_CONTROL, 16'h0005);
    wait_for(0, n);
    status(2'b01);
    snap(v1);
    chk(v1, 32'h5);
    u_timer_master.wr(ADDR_CONTROL, REG_ZERO);
    #1 chk({31'h0, irq}, 32'h0);
    u_timer_master.wr(ADDR_CONTROL, 16'h0001);
    #1 chk({31'h0, irq}, 32'h1);
    u_timer_master.wr(ADDR_STATUS, REG_ZERO);
    #1 chk({31'h0, irq}, 32'h0);
    status(2'b00);
    // Repeating run: zero pulses come period plus one cycles apart
    u_timer_master.wr(ADDR_CONTROL, 16'h0006);
    wait_for(1, n);
    wait_for(1, n);
    chk(n, 32'd6);
    wait_for(1, n);
    chk(n, 32'd6);
    status(2'b11);
    chk({31'h0, system_restart_request}, 32'h0);
    u_timer_master.wr(ADDR_CONTROL, 16'h0008);
    status(2'b01);
    // Period write while running in repeat mode must stop the counter
    u_timer_master.wr(ADDR_CONTROL, 16'h0006);
    u_timer_master.wr(ADDR_PER_LO, 16'h0005);
    status(2'b01);
    results();
  end
endmodule : interval_timer_regs_tb

// file: test/timer_master.sv
// Bus master model for the interval timer's register port.
// Assumes the timer takes address, strobes and data at rising ref_clk.
`timescale 1ns/1ps

module timer_master (
  input  wire logic        ref_clk,
  input  wire logic [15:0] readdata,
  output logic      [2:0]  address,
  output logic             write,
  output logic             read,
  output logic      [15:0] writedata
);
  // Idle bus at time zero
  initial begin
    address   = 3'h0;
    write     = 1'b0;
    read      = 1'b0;
    writedata = 16'hffff;
  end

  // One write; idle data is inverted so a stale value can never pass as fresh
  task automatic wr(input logic [2:0] a, input logic [15:0] d);
    @(posedge ref_clk);
    address   <= a;
    write     <= 1'b1;
    writedata <= d;
    @(posedge ref_clk);
    write     <= 1'b0;
    writedata <= ~d;
  endtask : wr

  // One read; data is taken once the taking edge has landed
  task automatic rd(input logic [2:0] a, output logic [15:0] d);
    @(posedge ref_clk);
    address <= a;
    read    <= 1'b1;
    @(posedge ref_clk);
    read    <= 1'b0;
    #1 d = readdata;
  endtask : rd
endmodule : timer_master

// file: verilog/interval_timer_pkg.sv
// Constants for the 32-bit down-counting interval timer register block.
// Assumes a single-clock register port with word addressing and 16-bit data.

package interval_timer_pkg;

  // --------------------------------------------------------------------------
  // Register map
  // --------------------------------------------------------------------------
  localparam logic [2:0] ADDR_STATUS  = 3'h0;
  localparam logic [2:0] ADDR_CONTROL = 3'h1;
  localparam logic [2:0] ADDR_PER_LO  = 3'h2;
  localparam logic [2:0] ADDR_PER_HI  = 3'h3;
  localparam logic [2:0] ADDR_CAP_LO  = 3'h4;
  localparam logic [2:0] ADDR_CAP_HI  = 3'h5;

  // --------------------------------------------------------------------------
  // Field positions
  // --------------------------------------------------------------------------
  localparam int BIT_ZERO_FLAG  = 0;
  localparam int BIT_RUNNING    = 1;
  localparam int BIT_IRQ_EN     = 0;
  localparam int BIT_REPEAT     = 1;
  localparam int BIT_START      = 2;
  localparam int BIT_STOP       = 3;

  // --------------------------------------------------------------------------
  // Widths and reset values
  // --------------------------------------------------------------------------
  localparam int         REG_WIDTH    = 16;
  localparam int         CNT_WIDTH    = 32;
  localparam logic [31:0] DEF_PERIOD  = 32'h0001_869f;
  localparam logic [31:0] CNT_ZERO    = 32'h0000_0000;
  localparam logic [15:0] REG_ZERO    = 16'h0000;

endpackage : interval_timer_pkg

// file: verilog/interval_timer_regs.sv
// Interval timer: six 16-bit registers, 32-bit down counter, options.
// Assumes the master's address, data and strobes are synchronous to ref_clk.
`timescale 1ns/1ps

module interval_timer_regs
  import interval_timer_pkg::*;
#(
  parameter logic [31:0] PERIOD_DEFAULT  = DEF_PERIOD,
  parameter bit          WRITABLE_PERIOD = 1'b1,
  parameter bit          HAS_SNAPSHOT    = 1'b1,
  parameter bit          HAS_START_STOP  = 1'b1,
  parameter bit          HAS_PULSE       = 1'b1,
  parameter bit          HAS_WATCHDOG    = 1'b0
) (
  input  wire  logic        ref_clk,
  input  wire  logic        rst_b,
  input  wire  logic [2:0]  address,
  input  wire  logic        write,
  input  wire  logic        read,
  input  wire  logic [15:0] writedata,
  output logic       [15:0] readdata,
  output logic              irq,
  output logic              zero_reach_pulse,
  output logic              system_restart_request
);

  // --------------------------------------------------------------------------
  // Build-time checks
  // --------------------------------------------------------------------------
  // Refused at elaboration: a watchdog must never be stoppable
  if (HAS_WATCHDOG && HAS_START_STOP) begin : g_bad_build
    $error("Watchdog build must not also have stop control");
  end

  // --------------------------------------------------------------------------
  // State
  // --------------------------------------------------------------------------
  logic [31:0] counter;
  logic [31:0] period;
  logic [31:0] capture;
  logic        running;
  logic        zero_reached_flag;
  logic        zero_irq_enable;
  logic        repeat_mode;

  // --------------------------------------------------------------------------
  // Decode
  // --------------------------------------------------------------------------
  wire wr_status  = write && (address == ADDR_STATUS);
  wire wr_control = write && (address == ADDR_CONTROL);
  wire wr_per_lo  = write && (address == ADDR_PER_LO);
  wire wr_per_hi  = write && (address == ADDR_PER_HI);
  wire wr_period  = wr_per_lo || wr_per_hi;
  wire wr_capture = write && ((address == ADDR_CAP_LO) || (address == ADDR_CAP_HI));

  // Start is present in watchdog builds even without start/stop control
  wire start_ok   = HAS_START_STOP || HAS_WATCHDOG;
  wire start_ev   = wr_control && writedata[BIT_START] && start_ok;
  // Stop has no effect without start/stop control, nor ever under watchdog
  wire stop_ev    = wr_control && writedata[BIT_STOP] && HAS_START_STOP
                    && !HAS_WATCHDOG;
  wire at_zero    = running && (counter == CNT_ZERO);
  wire load_src_w = WRITABLE_PERIOD && !HAS_WATCHDOG;

  // Period value as it will stand after this cycle's write
  wire [31:0] next_period =
      !load_src_w ? PERIOD_DEFAULT :
      wr_per_lo   ? {period[31:16], writedata} :
      wr_per_hi   ? {writedata, period[15:0]} : period;

  // A period write stops the counter only when stop control exists
  wire per_stop   = wr_period && HAS_START_STOP && !HAS_WATCHDOG;
  // Without any start control the timer runs free; a watchdog never stops at zero
  wire next_run   = !start_ok           ? 1'b1 :
                    stop_ev || per_stop ? 1'b0 :
                    start_ev            ? 1'b1 :
                    at_zero && !repeat_mode && !HAS_WATCHDOG ? 1'b0 : running;

  // Reload on zero or any period write; otherwise count down while running
  wire [31:0] next_counter =
      wr_period ? next_period :
      at_zero   ? period :
      running   ? counter - 32'h0000_0001 : counter;

  // --------------------------------------------------------------------------
  // Counter and run state
  // --------------------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      counter <= PERIOD_DEFAULT;
      period  <= PERIOD_DEFAULT;
      running <= 1'b0;
    end else begin
      counter <= next_counter;
      period  <= next_period;
      running <= next_run;
    end
  end

  // The run bit cannot be free-running before reset release in a watchdog,
  // so a non-watchdog build without start/stop starts itself on the first edge.
  logic auto_started;
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) auto_started <= 1'b0;
    else        auto_started <= 1'b1;
  end
  wire free_run = !HAS_START_STOP && !HAS_WATCHDOG && !auto_started;

  // --------------------------------------------------------------------------
  // Control and flag; a zero event wins over a same-cycle clear
  // --------------------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      zero_reached_flag <= 1'b0;
      zero_irq_enable   <= 1'b0;
      repeat_mode       <= 1'b0;
    end else begin
      if (at_zero)
        zero_reached_flag <= 1'b1;
      else if (wr_status && writedata == REG_ZERO)
        zero_reached_flag <= 1'b0;
      if (wr_control) begin
        zero_irq_enable <= writedata[BIT_IRQ_EN];
        repeat_mode     <= writedata[BIT_REPEAT];
      end else if (free_run) begin
        repeat_mode     <= 1'b1;  // Runs continuously without stop control
      end
    end
  end

  // --------------------------------------------------------------------------
  // Snapshot capture, whole word in one cycle
  // --------------------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b)                       capture <= CNT_ZERO;
    else if (wr_capture && HAS_SNAPSHOT) capture <= counter;
  end

  // --------------------------------------------------------------------------
  // Outputs
  // --------------------------------------------------------------------------
  logic        zero_q;
  wire  [15:0] rd_status  = {14'h0000, running, zero_reached_flag};
  wire  [15:0] rd_control = {14'h0000, repeat_mode, zero_irq_enable};
  wire  [15:0] next_rdata =
      (address == ADDR_STATUS)  ? rd_status :
      (address == ADDR_CONTROL) ? rd_control :
      (address == ADDR_PER_LO)  ? period[15:0] :
      (address == ADDR_PER_HI)  ? period[31:16] :
      (address == ADDR_CAP_LO)  ? capture[15:0] :
      (address == ADDR_CAP_HI)  ? capture[31:16] : REG_ZERO;

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      readdata <= REG_ZERO;
      zero_q   <= 1'b0;
    end else begin
      readdata <= read ? next_rdata : readdata;
      zero_q   <= at_zero;
    end
  end

  assign irq                    = zero_irq_enable && zero_reached_flag;
  assign zero_reach_pulse       = HAS_PULSE && zero_q;
  assign system_restart_request = HAS_WATCHDOG && zero_q;

  // --------------------------------------------------------------------------
  // Checks
  // --------------------------------------------------------------------------
  property p_flag_set;
    @(posedge ref_clk) disable iff (!rst_b) at_zero |=> zero_reached_flag;
  endproperty
  a_flag_set: assert property (p_flag_set) else $error("flag not set at zero");

  property p_flag_clear;
    @(posedge ref_clk) disable iff (!rst_b)
      (wr_status && writedata == REG_ZERO && !at_zero) |=> !zero_reached_flag;
  endproperty
  a_flag_clear: assert property (p_flag_clear) else $error("flag not cleared");

  property p_irq;
    @(posedge ref_clk) disable iff (!rst_b)
      (zero_irq_enable && at_zero && !wr_control) |=> irq;
  endproperty
  a_irq: assert property (p_irq) else $error("irq mismatch");

  property p_oneshot;
    @(posedge ref_clk) disable iff (!rst_b)
      (HAS_START_STOP && at_zero && !repeat_mode && !start_ev && !wr_period)
      |=> !running && counter == $past(period);
  endproperty
  a_oneshot: assert property (p_oneshot) else $error("one-shot did not stop");

  property p_reload;
    @(posedge ref_clk) disable iff (!rst_b)
      (at_zero && !wr_period) |=> counter == $past(period);
  endproperty
  a_reload: assert property (p_reload) else $error("no reload at zero");

  property p_count;
    @(posedge ref_clk) disable iff (!rst_b)
      (running && !at_zero && !wr_period && !stop_ev) |=> counter == $past(counter) - 32'h1;
  endproperty
  a_count: assert property (p_count) else $error("counter did not decrement");

  property p_start;
    @(posedge ref_clk) disable iff (!rst_b) (start_ev && !running && !wr_period) |=> running;
  endproperty
  a_start: assert property (p_start) else $error("start ignored");

  property p_stop;
    @(posedge ref_clk) disable iff (!rst_b) stop_ev |=> !running;
  endproperty
  a_stop: assert property (p_stop) else $error("stop ignored");

  property p_capture;
    @(posedge ref_clk) disable iff (!rst_b)
      (wr_capture && HAS_SNAPSHOT) |=> capture == $past(counter) ##1 1'b1;
  endproperty
  a_capture: assert property (p_capture) else $error("snapshot mismatch");

  property p_pulse;
    @(posedge ref_clk) disable iff (!rst_b)
      (HAS_PULSE && at_zero) |=> zero_reach_pulse ##1 !zero_reach_pulse;
  endproperty
  a_pulse: assert property (p_pulse) else $error("pulse width wrong");

  // Flag stays set until a zero write to status
  property p_flag_hold;
    @(posedge ref_clk) disable iff (!rst_b)
      (zero_reached_flag && !(wr_status && writedata == REG_ZERO)) |=> zero_reached_flag;
  endproperty
  a_flag_hold: assert property (p_flag_hold) else $error("flag lost");

  // Status writes never move the run bit
  property p_run_status;
    @(posedge ref_clk) disable iff (!rst_b)
      (wr_status && !at_zero) |=> running == $past(running);
  endproperty
  a_run_status: assert property (p_run_status) else $error("run bit moved");

  property p_read_status;
    @(posedge ref_clk) disable iff (!rst_b)
      (read && address == ADDR_STATUS)
      |=> readdata == {14'h0000, $past(running), $past(zero_reached_flag)};
  endproperty
  a_read_status: assert property (p_read_status) else $error("status read wrong");

  // Control write takes enable and mode bits as written
  property p_ctrl_write;
    @(posedge ref_clk) disable iff (!rst_b)
      wr_control |=> zero_irq_enable == $past(writedata[BIT_IRQ_EN])
                     && repeat_mode == $past(writedata[BIT_REPEAT]);
  endproperty
  a_ctrl_write: assert property (p_ctrl_write) else $error("control write lost");

  // A stopped counter keeps its value so a start resumes from it
  property p_stopped_hold;
    @(posedge ref_clk) disable iff (!rst_b)
      (!running && !start_ev && !wr_period) |=> counter == $past(counter);
  endproperty
  a_stopped_hold: assert property (p_stopped_hold) else $error("stopped count moved");

  property p_per_lo_read;
    @(posedge ref_clk) disable iff (!rst_b)
      (read && address == ADDR_PER_LO) |=> readdata == $past(period[15:0]);
  endproperty
  a_per_lo_read: assert property (p_per_lo_read) else $error("period low wrong");

  property p_per_hi_read;
    @(posedge ref_clk) disable iff (!rst_b)
      (read && address == ADDR_PER_HI) |=> readdata == $past(period[31:16]);
  endproperty
  a_per_hi_read: assert property (p_per_hi_read) else $error("period high wrong");

  // Any period write leaves the counter equal to the period in force
  property p_period_load;
    @(posedge ref_clk) disable iff (!rst_b)
      wr_period |=> counter == period;
  endproperty
  a_period_load: assert property (p_period_load) else $error("period not loaded");

  // The last decrement lands on zero, which is held for a cycle
  property p_hold_zero;
    @(posedge ref_clk) disable iff (!rst_b)
      (running && counter == 32'h0000_0001 && !wr_period && !stop_ev)
      |=> running && counter == CNT_ZERO;
  endproperty
  a_hold_zero: assert property (p_hold_zero) else $error("zero not held");

  property p_period_stop;
    @(posedge ref_clk) disable iff (!rst_b)
      (wr_period && HAS_START_STOP && !HAS_WATCHDOG) |=> !running;
  endproperty
  a_period_stop: assert property (p_period_stop) else $error("period write kept run");

  property p_capture_keeps;
    @(posedge ref_clk) disable iff (!rst_b)
      (wr_capture && !at_zero) |=> running == $past(running);
  endproperty
  a_capture_keeps: assert property (p_capture_keeps) else $error("snapshot moved run");

  property p_unmapped;
    @(posedge ref_clk) disable iff (!rst_b)
      (read && address > ADDR_CAP_HI) |=> readdata == REG_ZERO;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");

  // Read data stands until the next read
  property p_rd_hold;
    @(posedge ref_clk) disable iff (!rst_b)
      !read |=> readdata == $past(readdata);
  endproperty
  a_rd_hold: assert property (p_rd_hold) else $error("read data moved");

endmodule : interval_timer_regs
